// ---- src/ebr_consts.vh ----
// Constants for the EEPROM bus recovery and power-on control block
`ifndef EBR_CONSTS_VH
`define EBR_CONSTS_VH
// Init time in microseconds and clock period in nanoseconds
`define EBR_INIT_TIME_US 5000
`define EBR_CLK_PERIOD_NS 100
`define EBR_INIT_CYCLES ((`EBR_INIT_TIME_US * 1000) / `EBR_CLK_PERIOD_NS)
// Interface states
`define EBR_ST_INIT 3'h0
`define EBR_ST_IDLE 3'h1
`define EBR_ST_ADDR 3'h2
`define EBR_ST_ADDR_ACK 3'h3
`define EBR_ST_WRITE 3'h4
`define EBR_ST_WRITE_ACK 3'h5
`define EBR_ST_READ 3'h6
`define EBR_ST_READ_ACK 3'h7
// Device address upper bits (arbitrary choice, four-bit type code)
`define EBR_DEV_TYPE 4'ha
`endif

// ---- src/ebr_sync3.v ----
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module ebr_sync3 #(
    parameter RESET_VAL = 1'b1
) (
    input wire clk,
    input wire srst,
    input wire din,
    output reg dout
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    always @(posedge clk)
    begin
        if (srst)
        begin
            s1_reg <= RESET_VAL;
            s2_reg <= RESET_VAL;
            s3_reg <= RESET_VAL;
            dout <= RESET_VAL;
        end
        else
        begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // Change counts only once stages two and three agree
            if (s2_reg == s3_reg)
            begin
                dout <= s3_reg;
            end
        end
    end
endmodule // ebr_sync3

// ---- src/ebr_bus_ctrl.v ----
// Serial interface control of a two-wire EEPROM slave
`timescale 1ns/1ps
`include "ebr_consts.vh"
// Overview of operation
// - Stop under low supply aborts pending write
// - Low-supply data flagged as not guaranteed
// - No reset pin; only bus conditions reset
// - Start then stop resets interface machine
// - Master-only reset leaves state until stop
// - SDA high on dummy clock releases SDA
// - Start then stop after dummies readies device
// - Power-on clear initialises state automatically
// - Commands ignored during initialisation period
// - After init, enter standby awaiting start
// - SDA only pulled low or released
// - Undriven write-protect reads low
// - Start during command shifting cancels it
// - Write-protect high inhibits writes, no data ack
module ebr_bus_ctrl #(
    parameter INIT_CYCLES = `EBR_INIT_CYCLES,
    parameter [2:0] CHIP_SEL = 3'h0,
    parameter PAGE_BYTES = 16
) (
    input wire clk,
    input wire srst,
    input wire sclIn,
    input wire sdaIn,
    output wire sdaOut,
    output wire sdaOe,
    input wire wpIn,
    input wire wpDriven,
    input wire lowSupply,
    input wire [7:0] memRdData,
    output reg [7:0] wrData,
    output reg wrDataValid,
    output reg [7:0] wordAddr,
    output reg wordAddrValid,
    output reg writeStart,
    output reg writeAbort,
    output reg dataSuspect,
    output reg rdAdvance,
    output reg initDone,
    output reg [2:0] ifState
);
    // ==========================================================
    // Pin synchronisation
    // ==========================================================
    wire sclSync;
    wire sdaSync;
    wire wpSync;
    wire lowSync;
    wire wpEff;

    ebr_sync3 #(.RESET_VAL(1'b1)) u_sclSync (
        .clk(clk),
        .srst(srst),
        .din(sclIn),
        .dout(sclSync)
    );
    ebr_sync3 #(.RESET_VAL(1'b1)) u_sdaSync (
        .clk(clk),
        .srst(srst),
        .din(sdaIn),
        .dout(sdaSync)
    );
    ebr_sync3 #(.RESET_VAL(1'b0)) u_wpSync (
        .clk(clk),
        .srst(srst),
        // Internal pull-down when the pin floats
        .din(wpIn & wpDriven),
        .dout(wpSync)
    );
    ebr_sync3 #(.RESET_VAL(1'b1)) u_lowSync (
        .clk(clk),
        .srst(srst),
        .din(lowSupply),
        .dout(lowSync)
    );
    assign wpEff = wpSync;

    reg sclPrev_reg;
    reg sdaPrev_reg;
    wire sclRise;
    wire sclFall;
    wire startCond;
    wire stopCond;

    assign sclRise = sclSync & ~sclPrev_reg;
    assign sclFall = ~sclSync & sclPrev_reg;
    assign startCond = sclSync & sclPrev_reg & sdaPrev_reg & ~sdaSync;
    assign stopCond = sclSync & sclPrev_reg & ~sdaPrev_reg & sdaSync;

    // ==========================================================
    // Power-on clear timer
    // ==========================================================
    // srst stands in for the power-on-clear pulse; no pin resets this
    reg [31:0] initCnt_reg;
    always @(posedge clk)
    begin
        if (srst)
        begin
            initCnt_reg <= 32'h0;
            initDone <= 1'b0;
        end
        else if (!initDone)
        begin
            if (initCnt_reg >= INIT_CYCLES - 1)
            begin
                initDone <= 1'b1;
            end
            initCnt_reg <= initCnt_reg + 32'h1;
        end
    end

    // ==========================================================
    // Interface state machine
    // ==========================================================
    reg [3:0] bitCnt_reg;
    reg [7:0] shift_reg;
    reg addrPhase_reg;
    reg readMode_reg;
    reg [4:0] dataBytes_reg;
    reg lowSeen_reg;
    reg pullLow_reg;
    reg [7:0] txByte_reg;

    // Open drain: never drive high
    assign sdaOut = 1'b0;
    assign sdaOe = pullLow_reg;

    always @(posedge clk)
    begin
        if (srst)
        begin
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
            ifState <= `EBR_ST_INIT;
            bitCnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            addrPhase_reg <= 1'b0;
            readMode_reg <= 1'b0;
            dataBytes_reg <= 5'h00;
            lowSeen_reg <= 1'b0;
            pullLow_reg <= 1'b0;
            txByte_reg <= 8'h00;
            wrData <= 8'h00;
            wrDataValid <= 1'b0;
            wordAddr <= 8'h00;
            wordAddrValid <= 1'b0;
            writeStart <= 1'b0;
            writeAbort <= 1'b0;
            dataSuspect <= 1'b0;
            rdAdvance <= 1'b0;
        end
        else
        begin
            sclPrev_reg <= sclSync;
            sdaPrev_reg <= sdaSync;
            wrDataValid <= 1'b0;
            wordAddrValid <= 1'b0;
            writeStart <= 1'b0;
            writeAbort <= 1'b0;
            rdAdvance <= 1'b0;
            if (lowSync && ifState != `EBR_ST_INIT && ifState != `EBR_ST_IDLE)
            begin
                lowSeen_reg <= 1'b1;
            end
            if (ifState == `EBR_ST_INIT)
            begin
                // Bus activity ignored until init time elapses
                pullLow_reg <= 1'b0;
                if (initDone)
                begin
                    ifState <= `EBR_ST_IDLE;
                end
            end
            else if (stopCond)
            begin
                // A stop returns any held state to idle; master reset alone does not
                pullLow_reg <= 1'b0;
                // The stop's own SCL rise has already shifted one bit
                if (ifState == `EBR_ST_WRITE && bitCnt_reg == 4'h1 && dataBytes_reg != 5'h00
                    && !wpEff)
                begin
                    if (lowSync)
                    begin
                        writeAbort <= 1'b1;
                    end
                    else
                    begin
                        writeStart <= 1'b1;
                        dataSuspect <= lowSeen_reg;
                    end
                end
                lowSeen_reg <= 1'b0;
                ifState <= `EBR_ST_IDLE;
            end
            else if (startCond)
            begin
                // A start drops any command being shifted in
                pullLow_reg <= 1'b0;
                bitCnt_reg <= 4'h0;
                addrPhase_reg <= 1'b0;
                dataBytes_reg <= 5'h00;
                lowSeen_reg <= lowSync;
                ifState <= `EBR_ST_ADDR;
            end
            else if (sclRise)
            begin
                case (ifState)
                    `EBR_ST_ADDR, `EBR_ST_WRITE:
                    begin
                        shift_reg <= {shift_reg[6:0], sdaSync};
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end
                    `EBR_ST_READ_ACK:
                    begin
                        // Master nack ends reading; ack continues
                        if (sdaSync)
                        begin
                            ifState <= `EBR_ST_IDLE;
                        end
                        else
                        begin
                            rdAdvance <= 1'b1;
                        end
                    end
                    `EBR_ST_READ:
                    begin
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                        // SDA high while we release it for a zero bit means someone else; go idle
                        if (pullLow_reg == 1'b0 && sdaSync == 1'b1 && txByte_reg[7] == 1'b0)
                        begin
                            ifState <= `EBR_ST_IDLE;
                        end
                    end
                    default:
                    begin
                        bitCnt_reg <= bitCnt_reg;
                    end
                endcase
            end
            else if (sclFall)
            begin
                case (ifState)
                    `EBR_ST_ADDR:
                    begin
                        if (bitCnt_reg == 4'h8)
                        begin
                            bitCnt_reg <= 4'h0;
                            if (shift_reg[7:4] == `EBR_DEV_TYPE && shift_reg[3:1] == CHIP_SEL)
                            begin
                                readMode_reg <= shift_reg[0];
                                pullLow_reg <= 1'b1;
                                ifState <= `EBR_ST_ADDR_ACK;
                            end
                            else
                            begin
                                ifState <= `EBR_ST_IDLE;
                            end
                        end
                    end
                    `EBR_ST_ADDR_ACK:
                    begin
                        if (readMode_reg)
                        begin
                            txByte_reg <= memRdData;
                            pullLow_reg <= ~memRdData[7];
                            ifState <= `EBR_ST_READ;
                        end
                        else
                        begin
                            pullLow_reg <= 1'b0;
                            addrPhase_reg <= 1'b1;
                            ifState <= `EBR_ST_WRITE;
                        end
                    end
                    `EBR_ST_WRITE:
                    begin
                        if (bitCnt_reg == 4'h8)
                        begin
                            bitCnt_reg <= 4'h0;
                            ifState <= `EBR_ST_WRITE_ACK;
                            if (addrPhase_reg)
                            begin
                                wordAddr <= shift_reg;
                                wordAddrValid <= 1'b1;
                                pullLow_reg <= 1'b1;
                            end
                            else
                            begin
                                // Protected data bytes are not acknowledged
                                pullLow_reg <= ~wpEff;
                                if (!wpEff)
                                begin
                                    wrData <= shift_reg;
                                    wrDataValid <= 1'b1;
                                    if (dataBytes_reg != PAGE_BYTES)
                                    begin
                                        dataBytes_reg <= dataBytes_reg + 5'h01;
                                    end
                                end
                            end
                        end
                    end
                    `EBR_ST_WRITE_ACK:
                    begin
                        pullLow_reg <= 1'b0;
                        addrPhase_reg <= 1'b0;
                        ifState <= `EBR_ST_WRITE;
                    end
                    `EBR_ST_READ:
                    begin
                        if (bitCnt_reg == 4'h8)
                        begin
                            bitCnt_reg <= 4'h0;
                            pullLow_reg <= 1'b0;
                            ifState <= `EBR_ST_READ_ACK;
                        end
                        else
                        begin
                            txByte_reg <= {txByte_reg[6:0], 1'b0};
                            pullLow_reg <= ~txByte_reg[6];
                        end
                    end
                    `EBR_ST_READ_ACK:
                    begin
                        txByte_reg <= memRdData;
                        pullLow_reg <= ~memRdData[7];
                        ifState <= `EBR_ST_READ;
                    end
                    default:
                    begin
                        pullLow_reg <= 1'b0;
                    end
                endcase
            end
            // Dummy clock with SDA high in EBR_ST_ADDR_ACK or EBR_ST_WRITE_ACK while released: go idle
            if (!startCond && !stopCond && sclRise && sdaSync && pullLow_reg == 1'b0
                && (ifState == `EBR_ST_ADDR_ACK || ifState == `EBR_ST_WRITE_ACK))
            begin
                ifState <= `EBR_ST_IDLE;
            end
        end
    end
endmodule // ebr_bus_ctrl

// ---- verif/ebr_bus_ctrl_assertions.sv ----
// Concurrent checks on the EEPROM bus control ports
`timescale 1ns/1ps
`include "ebr_consts.vh"
module ebr_chk #(
    parameter INIT_CYCLES = 10
) (
    input wire clk,
    input wire srst,
    input wire sclIn,
    input wire sdaOut,
    input wire sdaOe,
    input wire wpIn,
    input wire wpDriven,
    input wire writeStart,
    input wire writeAbort,
    input wire initDone,
    input wire [2:0] ifState
);
    // ==========================================
    // Helper: cycles spent in initialisation
    reg [31:0] upCnt_reg;
    always @(posedge clk)
    begin
        if (srst)
            upCnt_reg <= 32'h0;
        else if (!initDone)
            upCnt_reg <= upCnt_reg + 32'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ==========================================
    // Properties
    property p_open_drain; sdaOut == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda driven high");
    // Synchroniser delay means SCL has been low for some cycles already
    property p_oe_scl_low; $rose(sdaOe) |-> !sclIn && !$past(sclIn, 4); endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("pull while scl high");
    property p_reset_state;
        $past(srst) |-> ifState == `EBR_ST_INIT && !initDone && !sdaOe;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("not cleared");
    property p_init_quiet; !initDone |-> ifState == `EBR_ST_INIT && !sdaOe; endproperty
    a_init_quiet: assert property (p_init_quiet) else $error("bus seen in init");
    property p_init_time;
        $rose(initDone) |-> upCnt_reg == INIT_CYCLES;
    endproperty
    a_init_time: assert property (p_init_time) else $error("init length wrong");
    property p_standby; $rose(initDone) |=> ifState == `EBR_ST_IDLE; endproperty
    a_standby: assert property (p_standby) else $error("no standby");
    property p_done_holds; initDone |=> initDone; endproperty
    a_done_holds: assert property (p_done_holds) else $error("init redone");
    property p_write_excl; !(writeStart && writeAbort); endproperty
    a_write_excl: assert property (p_write_excl) else $error("start and abort");
    property p_wp_blocks; writeStart |-> !(wpIn && wpDriven); endproperty
    a_wp_blocks: assert property (p_wp_blocks) else $error("write under wp");
    property p_write_idle;
        (writeStart || writeAbort) |-> ##[0:1] ifState == `EBR_ST_IDLE;
    endproperty
    a_write_idle: assert property (p_write_idle) else $error("stop not idle");
endmodule // ebr_chk

bind ebr_bus_ctrl ebr_chk #(.INIT_CYCLES(INIT_CYCLES)) chk (.clk(clk), .srst(srst),
    .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .wpIn(wpIn), .wpDriven(wpDriven),
    .writeStart(writeStart), .writeAbort(writeAbort), .initDone(initDone), .ifState(ifState));

// ---- verif/ebr_master_model.sv ----
// Two-wire bus master model driving SCL and releasing or pulling SDA
`timescale 1ns/1ps
module ebr_master_model #(
    parameter HALF = 20
) (
    input wire clk,
    input wire sdaWire,
    output reg scl,
    output reg sdaRel
);
    initial
    begin
        scl = 1'b1;
        sdaRel = 1'b1;
    end
    task hp;
        repeat (HALF) @(negedge clk);
    endtask
    // ==========================================
    // Bus conditions; the only reset the slave has
    task start;
        sdaRel = 1'b1;
        hp;
        scl = 1'b1;
        hp;
        sdaRel = 1'b0;
        hp;
        scl = 1'b0;
        hp;
    endtask
    task stop;
        sdaRel = 1'b0;
        hp;
        scl = 1'b1;
        hp;
        sdaRel = 1'b1;
        hp;
    endtask
    // Nine clocks, ack slot last; SDA waits after SCL fall to avoid false conditions
    task xfer(input [8:0] tx, output [8:0] rx);
        integer i;
        for (i = 8; i >= 0; i = i - 1)
        begin
            sdaRel = tx[i];
            hp;
            scl = 1'b1;
            hp;
            rx[i] = sdaWire;
            scl = 1'b0;
            repeat (HALF / 4) @(negedge clk);
        end
    endtask
    task dummy;
        reg [8:0] junk;
        xfer(9'h1ff, junk);
    endtask
endmodule // ebr_master_model

// ---- verif/ebr_bus_ctrl_tb_top.sv ----
// Self-checking bench for the EEPROM bus control block
`timescale 1ns/1ps
`include "ebr_consts.vh"
module ebr_bus_ctrl_tb_top;
    localparam INIT = 200;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg wpIn, wpDriven, lowSupply;
    reg [7:0] memRdData;
    wire sclIn, mRel, sdaIn, sdaOut, sdaOe, wrDataValid, wordAddrValid;
    wire writeStart, writeAbort, dataSuspect, rdAdvance, initDone;
    wire [7:0] wrData, wordAddr;
    wire [2:0] ifState;
    integer error_cnt, checks_done, i, k, n0, n1, n2, n3, seed;
    integer wsCnt = 0;
    integer waCnt = 0;
    integer wdCnt = 0;
    integer wvCnt = 0;
    integer raCnt = 0;
    reg [7:0] a, d;
    reg [2:0] acks;
    reg [8:0] r;
    // Pull-up: low when either party pulls
    assign sdaIn = mRel & ~(sdaOe & ~sdaOut);
    always #50 clk = ~clk;
    ebr_master_model m (.clk(clk), .sdaWire(sdaIn), .scl(sclIn), .sdaRel(mRel));
    ebr_bus_ctrl #(.INIT_CYCLES(INIT)) uut (.clk(clk), .srst(srst), .sclIn(sclIn),
        .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .wpIn(wpIn), .wpDriven(wpDriven),
        .lowSupply(lowSupply), .memRdData(memRdData), .wrData(wrData),
        .wrDataValid(wrDataValid), .wordAddr(wordAddr), .wordAddrValid(wordAddrValid),
        .writeStart(writeStart), .writeAbort(writeAbort), .dataSuspect(dataSuspect),
        .rdAdvance(rdAdvance), .initDone(initDone), .ifState(ifState));
    always @(posedge clk)
    begin
        if (writeStart === 1'b1)
            wsCnt <= wsCnt + 1;
        if (writeAbort === 1'b1)
            waCnt <= waCnt + 1;
        if (wrDataValid === 1'b1)
            wdCnt <= wdCnt + 1;
        if (wordAddrValid === 1'b1)
            wvCnt <= wvCnt + 1;
        if (rdAdvance === 1'b1)
            raCnt <= raCnt + 1;
    end
    // ==========================================
    // Shared tasks
    task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr_tx(input [7:0] wa, input [7:0] wd);
        m.start;
        m.xfer({`EBR_DEV_TYPE, 3'h0, 1'b0, 1'b1}, r);
        acks[2] = r[0];
        m.xfer({wa, 1'b1}, r);
        acks[1] = r[0];
        m.xfer({wd, 1'b1}, r);
        acks[0] = r[0];
        m.stop;
        repeat (30) @(negedge clk);
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        error_cnt = 0;
        checks_done = 0;
        {lowSupply, wpIn, wpDriven} = 3'h1;
        memRdData = 8'h00;
        seed = $urandom(4039);
        repeat (10) @(negedge clk);
        srst = 1'b0;
        m.start;
        chk("stateInit", ifState, `EBR_ST_INIT);
        chk("oeInit", sdaOe, 1'b0);
        for (i = 0; i < 1000 && initDone !== 1'b1; i = i + 1)
            @(negedge clk);
        if (initDone !== 1'b1)
        begin
            error_cnt = error_cnt + 1;
            stop_test;
        end
        @(negedge clk);
        chk("stateIdle", ifState, `EBR_ST_IDLE);
        m.stop;
        $display("init test done");
        // Normal, low supply, driven WP high, undriven WP high
        for (k = 0; k < 4; k = k + 1)
        begin
            {lowSupply, wpIn, wpDriven} = (k == 0) ? 3'h1 : (k == 1) ? 3'h5
                : (k == 2) ? 3'h3 : 3'h2;
            a = $urandom;
            d = $urandom;
            memRdData = $urandom;
            n0 = wsCnt;
            n1 = waCnt;
            n2 = wdCnt;
            n3 = wvCnt;
            wr_tx(a, d);
            chk("acks", acks, {2'b00, k == 2});
            chk("wrCount", wsCnt - n0, k == 0 || k == 3);
            chk("abCount", waCnt - n1, k == 1);
            chk("wdCount", wdCnt - n2, k != 2);
            chk("wvCount", wvCnt - n3, 1);
            if (k == 0)
            begin
                chk("noSuspect", dataSuspect, 1'b0);
                chk("wrData", wrData, d);
                chk("wordAddr", wordAddr, a);
            end
        end
        {lowSupply, wpIn, wpDriven} = 3'h1;
        // Supply dips during the transfer but is back before the stop
        n0 = wsCnt;
        lowSupply = 1'b1;
        m.start;
        m.xfer({`EBR_DEV_TYPE, 3'h0, 1'b0, 1'b1}, r);
        lowSupply = 1'b0;
        m.xfer({8'h3c, 1'b1}, r);
        m.xfer({8'hc3, 1'b1}, r);
        m.stop;
        repeat (30) @(negedge clk);
        chk("suspect", dataSuspect, 1'b1);
        chk("suspectWr", wsCnt - n0, 1);
        $display("write test done");
        n0 = wsCnt;
        m.start;
        m.xfer({`EBR_DEV_TYPE, 3'h0, 1'b0, 1'b1}, r);
        m.xfer({8'h5a, 1'b1}, r);
        m.start;
        m.stop;
        repeat (30) @(negedge clk);
        chk("cancelIdle", ifState, `EBR_ST_IDLE);
        chk("cancelNoWr", wsCnt - n0, 0);
        $display("cancel test done");
        memRdData = $urandom;
        n1 = raCnt;
        m.start;
        m.xfer({`EBR_DEV_TYPE, 3'h0, 1'b1, 1'b1}, r);
        m.xfer(9'h1fe, r);
        chk("rdByte", r[8:1], memRdData);
        chk("rdAdv", raCnt - n1, 1);
        m.xfer(9'h1ff, r);
        chk("rdNext", r[8:1], memRdData);
        m.stop;
        repeat (30) @(negedge clk);
        chk("rdEnd", ifState, `EBR_ST_IDLE);
        // All-zero byte keeps the slave pulling SDA low
        memRdData = 8'h00;
        $display("read test done");
        // Slave left holding a zero bit while the master restarts
        m.start;
        m.xfer({`EBR_DEV_TYPE, 3'h0, 1'b1, 1'b1}, r);
        chk("rdAck", r[0], 1'b0);
        repeat (200) @(negedge clk);
        chk("holdState", ifState, `EBR_ST_READ);
        chk("holdOe", sdaOe, 1'b1);
        m.dummy;
        chk("dummyRel", sdaOe, 1'b0);
        m.start;
        m.stop;
        repeat (30) @(negedge clk);
        chk("recIdle", ifState, `EBR_ST_IDLE);
        chk("recNoWr", wsCnt - n0, 0);
        wr_tx(8'h00, 8'hff);
        chk("recReady", acks, 3'h0);
        $display("recovery test done");
        stop_test;
    end
endmodule // ebr_bus_ctrl_tb_top
